/* src/bscs_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef BSCS_REGS_SVH
`define BSCS_REGS_SVH
`define BSCS_OFF_CTRL 8'h00
`define BSCS_OFF_STATUS 8'h04
`define BSCS_OFF_IRQ_STAT 8'h08
`define BSCS_OFF_IRQ_MASK 8'h0C
`define BSCS_EV_ALIGN_DONE 0
`define BSCS_EV_RAMP_DONE 1
`define BSCS_EV_UV 2
`define BSCS_EV_ILIM 3
`define BSCS_EV_W 4
`define BSCS_ST_MODE_LSB 0
`define BSCS_ST_COMM_LSB 3
`define BSCS_ST_UV 10
`define BSCS_ST_BRAKE 11
`define BSCS_ST_ONESHOT 12
`define BSCS_ST_LC_HOLD 13
`define BSCS_CLK_PERIOD_NS 25
`define BSCS_TOFF_NS 20000
`define BSCS_TOFF_CYC \
  ((`BSCS_TOFF_NS + `BSCS_CLK_PERIOD_NS - 1) / `BSCS_CLK_PERIOD_NS)
`define BSCS_IRQ_MASK_RESET 4'h0
`define BSCS_SAW_LO_MV 1700
`define BSCS_SAW_HI_MV 3900
`endif

/* src/bscs_pkg.sv */
// Mode and commutation state types
package bscs_pkg;
  typedef enum logic [2:0] {
    BSCS_ALIGN = 3'b001,
    BSCS_RAMP = 3'b010,
    BSCS_RUN = 3'b100
  } bscs_mode_t;
  typedef enum logic [6:0] {
    BSCS_ST_R = 7'b0000001,
    BSCS_ST_A = 7'b0000010,
    BSCS_ST_B = 7'b0000100,
    BSCS_ST_C = 7'b0001000,
    BSCS_ST_D = 7'b0010000,
    BSCS_ST_E = 7'b0100000,
    BSCS_ST_F = 7'b1000000
  } bscs_comm_t;
endpackage : bscs_pkg

/* src/bscs_pwm_saw.sv */
// Sawtooth generator and compensation-level comparator for PWM duty
`timescale 1ns/10ps
`include "bscs_regs.svh"
module bscs_pwm_saw
  import bscs_pkg::*;
#(
  parameter int W = 13,
  parameter logic [12:0] LO = 13'(`BSCS_SAW_LO_MV),
  parameter logic [12:0] HI = 13'(`BSCS_SAW_HI_MV)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] level,
  output logic pwm_on
);
  logic [W-1:0] saw;

  // Sawtooth runs from LO to HI in millivolt steps, then snaps back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      saw <= LO;
    end else if (saw >= HI) begin
      saw <= LO;
    end else begin
      saw <= W'(saw + 1'b1);
    end
  end

  // Higher level stays above the ramp longer, so on-time grows
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_on <= 1'b0;
    end else begin
      pwm_on <= (level > saw);
    end
  end

  chk_saw_range: assert property (@(posedge clk) disable iff (!rst_n)
    saw >= LO && saw <= HI)
    else $error("sawtooth out of range");
endmodule : bscs_pwm_saw

/* src/bscs_seq.sv */
// Start-up and commutation sequencer with driver gating and AXI4-Lite
// What this block does
// - Power-up enters align, state R parks rotor
// - Align comparator trip moves directly to ramp
// - Ramp steps states A to F on commutation clock
// - Ramp comparator trip moves to run
// - Back-EMF sampler disabled during ramp
// - Run enables back-EMF sensing, loop commutates
// - Duty from compensation level versus sawtooth
// - Outside brake, lows conduct only with PWM on, one-shot idle
// - Hold lower C off until upper C risen
// - Brake: all lows on, all uppers off
// - Brake disables current-limit one-shot
// - Undervoltage drives supply low flag low
// - Undervoltage turns off all six drivers
// - Lockout releases only above hysteresis level
// - States A to F drive their documented driver pair; R drives lower B with uppers A and C
// - Sampler selects the undriven phase
// - Overcurrent fires off-time one-shot on lows
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "bscs_regs.svh"
module bscs_seq
  import bscs_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int LEVEL_W = 13
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic COMM_CLK,
  input wire logic ALIGN_TRIP,
  input wire logic RAMP_TRIP,
  input wire logic [LEVEL_W-1:0] SPEED_COMP_MV,
  input wire logic SENSE_OVER_LIMIT,
  input wire logic BRAKE_N,
  input wire logic SUPPLY_AT_TRIP,
  input wire logic SUPPLY_ABOVE_RELEASE,
  input wire logic UPPER_C_RISEN,
  output logic LOWER_SWITCH_A,
  output logic LOWER_SWITCH_B,
  output logic LOWER_SWITCH_C,
  output logic UPPER_SWITCH_A_N,
  output logic UPPER_SWITCH_B_N,
  output logic UPPER_SWITCH_C_N,
  output logic SUPPLY_LOW_FLAG_N,
  output logic SAMPLER_EN,
  output logic [2:0] SAMPLE_SEL,
  output logic RAMP_SOURCE_EN,
  output logic IRQ,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  bscs_mode_t mode;
  bscs_comm_t comm;
  logic comm_prev;
  logic comm_rise;
  logic lc_hold;
  logic uv;
  logic [15:0] os_cnt;
  logic [15:0] os_time;
  logic os_active;
  logic pwm_on;
  logic [`BSCS_EV_W-1:0] irq_stat;
  logic [`BSCS_EV_W-1:0] irq_mask;
  logic [`BSCS_EV_W-1:0] ev;
  logic [2:0] next_low;
  logic [2:0] next_up_n;
  logic [2:0] tab_low;
  logic [2:0] tab_up;
  logic aw_got;
  logic w_got;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic [31:0] rd_word;
  logic rd_ok;
  logic [31:0] status_word;

  bscs_pwm_saw #(.W(LEVEL_W)) u_pwm (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .level(SPEED_COMP_MV),
    .pwm_on(pwm_on)
  );

  // Commutation clock arrives as a synchronous level; step on its rise
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      comm_prev <= 1'b0;
    end else begin
      comm_prev <= COMM_CLK;
    end
  end
  assign comm_rise = COMM_CLK && !comm_prev;

  // Start-up mode; run is left only by power removal
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      mode <= BSCS_ALIGN;
    end else begin
      case (mode)
        BSCS_ALIGN: if (ALIGN_TRIP) mode <= BSCS_RAMP;
        BSCS_RAMP: if (RAMP_TRIP) mode <= BSCS_RUN;
        BSCS_RUN: mode <= BSCS_RUN;
        default: mode <= BSCS_ALIGN;
      endcase
    end
  end

  // Seven-state commutation machine, parked in R during align
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      comm <= BSCS_ST_R;
    end else if (mode == BSCS_ALIGN) begin
      comm <= ALIGN_TRIP ? BSCS_ST_A : BSCS_ST_R;
    end else if (comm_rise) begin
      case (comm)
        BSCS_ST_A: comm <= BSCS_ST_B;
        BSCS_ST_B: comm <= BSCS_ST_C;
        BSCS_ST_C: comm <= BSCS_ST_D;
        BSCS_ST_D: comm <= BSCS_ST_E;
        BSCS_ST_E: comm <= BSCS_ST_F;
        default: comm <= BSCS_ST_A;
      endcase
    end
  end

  // Upper C may still conduct after R; keep lower C off until it rises
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      lc_hold <= 1'b0;
    end else if (mode == BSCS_ALIGN && ALIGN_TRIP) begin
      lc_hold <= 1'b1;
    end else if (UPPER_C_RISEN) begin
      lc_hold <= 1'b0;
    end
  end

  // Lockout with hysteresis: trip and release are separate comparators
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      uv <= 1'b0;
    end else if (SUPPLY_AT_TRIP) begin
      uv <= 1'b1;
    end else if (SUPPLY_ABOVE_RELEASE) begin
      uv <= 1'b0;
    end
  end

  // Current-limit off-time; braking keeps it idle
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      os_cnt <= 16'h0000;
    end else if (!BRAKE_N) begin
      os_cnt <= 16'h0000;
    end else if (SENSE_OVER_LIMIT && os_cnt == 16'h0000) begin
      os_cnt <= os_time;
    end else if (os_cnt != 16'h0000) begin
      os_cnt <= os_cnt - 16'h0001;
    end
  end
  assign os_active = (os_cnt != 16'h0000);

  // Driver pair per state; R drives lower B with both uppers A and C
  always_comb begin
    tab_low = 3'b000;
    tab_up = 3'b000;
    case (comm)
      BSCS_ST_R: begin tab_low = 3'b010; tab_up = 3'b101; end
      BSCS_ST_A: begin tab_low = 3'b100; tab_up = 3'b001; end
      BSCS_ST_B: begin tab_low = 3'b100; tab_up = 3'b010; end
      BSCS_ST_C: begin tab_low = 3'b001; tab_up = 3'b010; end
      BSCS_ST_D: begin tab_low = 3'b001; tab_up = 3'b100; end
      BSCS_ST_E: begin tab_low = 3'b010; tab_up = 3'b100; end
      BSCS_ST_F: begin tab_low = 3'b010; tab_up = 3'b001; end
      default: begin tab_low = 3'b000; tab_up = 3'b000; end
    endcase
  end

  // Override priority: lockout, then brake, then gated commutation
  always_comb begin
    if (uv) begin
      next_low = 3'b000;
      next_up_n = 3'b111;
    end else if (!BRAKE_N) begin
      next_low = 3'b111;
      next_up_n = 3'b111;
    end else begin
      next_low = (pwm_on && !os_active) ? tab_low : 3'b000;
      if (lc_hold) begin
        next_low[2] = 1'b0;
      end
      next_up_n = ~tab_up;
    end
  end

  // Drivers come from flops so the pins never glitch on decode
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      {LOWER_SWITCH_C, LOWER_SWITCH_B, LOWER_SWITCH_A} <= 3'b000;
      {UPPER_SWITCH_C_N, UPPER_SWITCH_B_N, UPPER_SWITCH_A_N} <= 3'b111;
    end else begin
      {LOWER_SWITCH_C, LOWER_SWITCH_B, LOWER_SWITCH_A} <= next_low;
      {UPPER_SWITCH_C_N, UPPER_SWITCH_B_N, UPPER_SWITCH_A_N} <= next_up_n;
    end
  end

  // Sampler routing follows the undriven phase; bit 0 is phase A
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      SAMPLE_SEL <= 3'b000;
    end else begin
      case (comm)
        BSCS_ST_A, BSCS_ST_D: SAMPLE_SEL <= 3'b010;
        BSCS_ST_B, BSCS_ST_E: SAMPLE_SEL <= 3'b001;
        BSCS_ST_C, BSCS_ST_F: SAMPLE_SEL <= 3'b100;
        default: SAMPLE_SEL <= 3'b000;
      endcase
    end
  end

  assign SAMPLER_EN = (mode == BSCS_RUN);
  assign RAMP_SOURCE_EN = (mode == BSCS_RAMP);
  assign SUPPLY_LOW_FLAG_N = !uv;

  // Interrupt events; a set in the clearing cycle wins
  always_comb begin
    ev = '0;
    ev[`BSCS_EV_ALIGN_DONE] = (mode == BSCS_ALIGN) && ALIGN_TRIP;
    ev[`BSCS_EV_RAMP_DONE] = (mode == BSCS_RAMP) && RAMP_TRIP;
    ev[`BSCS_EV_UV] = SUPPLY_AT_TRIP && !uv;
    ev[`BSCS_EV_ILIM] = BRAKE_N && SENSE_OVER_LIMIT && !os_active;
  end

  // AXI4-Lite write side: address and data taken in either order
  assign S_AXI_AWREADY = !aw_got && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_got && !S_AXI_BVALID;
  assign wr_fire = aw_got && w_got && !S_AXI_BVALID;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      aw_got <= 1'b0;
      aw_addr <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_got <= 1'b1;
      aw_addr <= S_AXI_AWADDR;
    end else if (wr_fire) begin
      aw_got <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      w_got <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_got <= 1'b1;
      w_data <= S_AXI_WDATA;
      w_strb <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_got <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      if (aw_addr == ADDR_W'(`BSCS_OFF_CTRL) ||
          aw_addr == ADDR_W'(`BSCS_OFF_STATUS) ||
          aw_addr == ADDR_W'(`BSCS_OFF_IRQ_STAT) ||
          aw_addr == ADDR_W'(`BSCS_OFF_IRQ_MASK)) begin
        S_AXI_BRESP <= 2'h0;
      end else begin
        S_AXI_BRESP <= 2'h2;
      end
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Off-time register steers the one-shot length
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      os_time <= 16'(`BSCS_TOFF_CYC);
    end else if (wr_fire && aw_addr == ADDR_W'(`BSCS_OFF_CTRL)) begin
      if (w_strb[0]) os_time[7:0] <= w_data[7:0];
      if (w_strb[1]) os_time[15:8] <= w_data[15:8];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      irq_mask <= `BSCS_IRQ_MASK_RESET;
    end else if (wr_fire && w_strb[0] &&
                 aw_addr == ADDR_W'(`BSCS_OFF_IRQ_MASK)) begin
      irq_mask <= w_data[`BSCS_EV_W-1:0];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      irq_stat <= '0;
    end else if (wr_fire && w_strb[0] &&
                 aw_addr == ADDR_W'(`BSCS_OFF_IRQ_STAT)) begin
      irq_stat <= (irq_stat & ~w_data[`BSCS_EV_W-1:0]) | ev;
    end else begin
      irq_stat <= irq_stat | ev;
    end
  end
  assign IRQ = |(irq_stat & irq_mask);

  // Read side: one cycle from address to data
  always_comb begin
    status_word = 32'h00000000;
    status_word[`BSCS_ST_MODE_LSB +: 3] = mode;
    status_word[`BSCS_ST_COMM_LSB +: 7] = comm;
    status_word[`BSCS_ST_UV] = uv;
    status_word[`BSCS_ST_BRAKE] = !BRAKE_N;
    status_word[`BSCS_ST_ONESHOT] = os_active;
    status_word[`BSCS_ST_LC_HOLD] = lc_hold;
    rd_ok = 1'b1;
    if (S_AXI_ARADDR == ADDR_W'(`BSCS_OFF_CTRL)) begin
      rd_word = {16'h0000, os_time};
    end else if (S_AXI_ARADDR == ADDR_W'(`BSCS_OFF_STATUS)) begin
      rd_word = status_word;
    end else if (S_AXI_ARADDR == ADDR_W'(`BSCS_OFF_IRQ_STAT)) begin
      rd_word = {28'h0000000, irq_stat};
    end else if (S_AXI_ARADDR == ADDR_W'(`BSCS_OFF_IRQ_MASK)) begin
      rd_word = {28'h0000000, irq_mask};
    end else begin
      rd_word = 32'h00000000;
      rd_ok = 1'b0;
    end
  end

  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= 2'h0;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_word;
      S_AXI_RRESP <= rd_ok ? 2'h0 : 2'h2;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  chk_align_park: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    mode == BSCS_ALIGN && !uv && BRAKE_N |=>
    !UPPER_SWITCH_A_N && !UPPER_SWITCH_C_N && UPPER_SWITCH_B_N)
    else $error("align does not park rotor");
  chk_align_exit: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    mode == BSCS_ALIGN && ALIGN_TRIP |=>
    mode == BSCS_RAMP && comm == BSCS_ST_A)
    else $error("align trip did not start ramp in A");
  chk_comm_step: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    mode == BSCS_RAMP && comm == BSCS_ST_F && comm_rise |=>
    comm == BSCS_ST_A)
    else $error("state F did not wrap to A");
  chk_ramp_exit: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    mode == BSCS_RAMP && RAMP_TRIP |=> mode == BSCS_RUN)
    else $error("ramp trip did not enter run");
  chk_ramp_sampler: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    $rose(mode == BSCS_RAMP) |-> !SAMPLER_EN [*2])
    else $error("sampler enabled in ramp");
  chk_lc_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    mode == BSCS_ALIGN && ALIGN_TRIP ##1 !UPPER_C_RISEN |=>
    !LOWER_SWITCH_C)
    else $error("lower C driven before upper C rose");
  chk_brake_all: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !uv && !BRAKE_N |=> LOWER_SWITCH_A && LOWER_SWITCH_B &&
    LOWER_SWITCH_C && UPPER_SWITCH_A_N && UPPER_SWITCH_B_N &&
    UPPER_SWITCH_C_N)
    else $error("brake pattern wrong");
  chk_uv_off: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    SUPPLY_AT_TRIP ##1 1'b1 |=> !SUPPLY_LOW_FLAG_N && !LOWER_SWITCH_A &&
    !LOWER_SWITCH_B && !LOWER_SWITCH_C && UPPER_SWITCH_A_N &&
    UPPER_SWITCH_B_N && UPPER_SWITCH_C_N)
    else $error("lockout did not disable drivers");
  chk_oneshot_len: assert property (@(posedge CLK_SYS)
    disable iff (!RST_N)
    BRAKE_N && SENSE_OVER_LIMIT && !os_active |=>
    os_cnt == $past(os_time))
    else $error("one-shot loaded wrong length");
  chk_run_sticky: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    mode == BSCS_RUN |=> mode == BSCS_RUN && SAMPLER_EN)
    else $error("run mode was left");
endmodule : bscs_seq

/* verification/bscs_stage_model.sv */
// Three-phase bridge model: upper C rise delay, sense line, shoot-through
`timescale 1ns/10ps
module bscs_stage_model #(
  parameter int RISE_CYC = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] lower,
  input wire logic [2:0] upper_n,
  input wire logic overload,
  output logic c_risen,
  output logic over_limit,
  output int shoot
);
  int rise_cnt;
  // The phase C node takes time to rise once its upper switch lets go
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_cnt <= 0;
    end else if (!upper_n[0]) begin
      rise_cnt <= 0;
    end else if (rise_cnt < RISE_CYC) begin
      rise_cnt <= rise_cnt + 1;
    end
  end
  assign c_risen = (rise_cnt >= RISE_CYC);
  // Overcurrent only shows while some low switch conducts
  assign over_limit = overload && (lower != 3'h0);
  // Both switches of one leg on together shorts the bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shoot <= 0;
    end else if ((lower & ~upper_n) != 3'h0) begin
      shoot <= shoot + 1;
    end
  end
endmodule : bscs_stage_model

/* verification/tb.sv */
// Self-checking bench for the start-up and commutation sequencer
`timescale 1ns/10ps
module tb;
  import bscs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic comm_clk = 1'b0, align_trip = 1'b0, ramp_trip = 1'b0;
  logic [12:0] level = 13'hFA0;
  logic brake_n = 1'b1, at_trip = 1'b0, above_rel = 1'b1, overload = 1'b0;
  logic c_risen, over_lim, flag_n, smp_en, ramp_en, irq;
  logic [2:0] lower, upper_n, sel;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  int err_total = 0, num_checks = 0, cyc = 0, shoot, st = 0, md = 1, cnt;
  int lo_tab[7] = '{2, 1, 1, 4, 4, 2, 2};
  int upn_tab[7] = '{2, 3, 5, 5, 6, 6, 3};
  int sel_tab[7] = '{0, 2, 1, 4, 2, 1, 4};
  int lv[4];

  always #12.5 clk = ~clk;

  bscs_seq u_dut (.CLK_SYS(clk), .RST_N(rst_n), .COMM_CLK(comm_clk),
    .ALIGN_TRIP(align_trip), .RAMP_TRIP(ramp_trip), .SPEED_COMP_MV(level),
    .SENSE_OVER_LIMIT(over_lim), .BRAKE_N(brake_n),
    .SUPPLY_AT_TRIP(at_trip), .SUPPLY_ABOVE_RELEASE(above_rel),
    .UPPER_C_RISEN(c_risen), .LOWER_SWITCH_A(lower[2]),
    .LOWER_SWITCH_B(lower[1]), .LOWER_SWITCH_C(lower[0]),
    .UPPER_SWITCH_A_N(upper_n[2]), .UPPER_SWITCH_B_N(upper_n[1]),
    .UPPER_SWITCH_C_N(upper_n[0]), .SUPPLY_LOW_FLAG_N(flag_n),
    .SAMPLER_EN(smp_en), .SAMPLE_SEL(sel), .RAMP_SOURCE_EN(ramp_en),
    .IRQ(irq), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready));

  bscs_stage_model u_stage (.clk(clk), .rst_n(rst_n), .lower(lower),
    .upper_n(upper_n), .overload(overload), .c_risen(c_risen),
    .over_limit(over_lim), .shoot(shoot));

  task stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // Ceiling well above the roughly 9000 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      stop_test();
    end
  end

  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk_val

  // Drivers, sampled phase and mode enables against the state table
  task chk_drv(input string nm, input bit lc_ok);
    logic [5:0] e;
    e = {3'(lo_tab[st]), 3'(upn_tab[st])};
    if (!lc_ok) e[3] = 1'b0;
    chk_val({nm, " drivers"}, 32'(e), 32'({lower, upper_n}));
    chk_val({nm, " sample"}, 32'(sel_tab[st]), 32'(sel));
    chk_val({nm, " mode"}, {30'h0, md == 4, md == 2}, {30'h0, smp_en, ramp_en});
  endtask : chk_drv

  // Ready is sampled at the edge; valid drops only after it was seen
  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    bit done;
    done = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        rs = bresp;
        done = 1;
      end
    end
    bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    bit done;
    done = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        d = rdata;
        rs = rresp;
        done = 1;
      end
    end
    rready <= 1'b0;
  endtask : axi_rd

  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e,
              input logic [1:0] er);
    axi_rd(a, v, r);
    chk_val(nm, e, v);
    chk_val({nm, " rresp"}, 32'(er), 32'(r));
  endtask : rd_chk

  task wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    axi_wr(a, d, r);
    chk_val("bresp", 32'(er), 32'(r));
  endtask : wr_chk

  task chk_status();
    axi_rd(8'h04, v, r);
    chk_val("status", 32'(md | (1 << (3 + st))), v & 32'h3FF);
  endtask : chk_status

  // Step on a rising commutation clock seen by the sequencer
  task step();
    @(posedge clk) comm_clk <= 1'b1;
    tick(2);
    @(posedge clk) comm_clk <= 1'b0;
    st = (st == 6) ? 1 : st + 1;
    tick(2);
  endtask : step

  initial begin
    v = $urandom(32'h6E80);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    tick(3);
    chk_drv("align", 1);
    chk_val("flag", 32'h1, 32'(flag_n));
    rd_chk("ctrl", 8'h00, 32'h320, 2'h0);
    rd_chk("mask", 8'h0C, 32'h0, 2'h0);
    rd_chk("unmapped", 8'h10, 32'h0, 2'h2);
    wr_chk(8'h10, 32'h1, 2'h2);
    wr_chk(8'h04, 32'hFFFFFFFF, 2'h0);
    chk_status();
    $display("test reset done");
    @(posedge clk) align_trip <= 1'b1;
    md = 2;
    st = 1;
    tick(3);
    chk_drv("ramp entry", 0);
    tick(12);
    chk_drv("ramp A", 1);
    for (int i = 0; i < 7; i++) begin
      step();
      chk_drv("ramp step", 1);
    end
    chk_status();
    $display("test ramp done");
    @(posedge clk) ramp_trip <= 1'b1;
    md = 4;
    tick(3);
    chk_drv("run", 1);
    @(posedge clk);
    align_trip <= 1'b0;
    ramp_trip <= 1'b0;
    step();
    chk_drv("run step", 1);
    chk_status();
    $display("test run done");
    rd_chk("irq stat", 8'h08, 32'h3, 2'h0);
    chk_val("irq masked", 32'h0, 32'(irq));
    wr_chk(8'h08, 32'h3, 2'h0);
    rd_chk("irq cleared", 8'h08, 32'h0, 2'h0);
    wr_chk(8'h00, 32'h32, 2'h0);
    wr_chk(8'h0C, 32'h8, 2'h0);
    @(posedge clk) overload <= 1'b1;
    @(posedge clk) overload <= 1'b0;
    tick(2);
    chk_val("limit cut", 32'h0, 32'(lower));
    chk_val("irq raised", 32'h1, 32'(irq));
    tick(44);
    chk_val("limit hold", 32'h0, 32'(lower));
    tick(8);
    chk_val("limit end", 32'(lo_tab[st]), 32'(lower));
    wr_chk(8'h08, 32'h8, 2'h0);
    tick(1);
    chk_val("irq clear", 32'h0, 32'(irq));
    $display("test current limit done");
    lv[0] = 1701;
    lv[1] = 3900;
    lv[2] = 1700 + ($urandom % 2201);
    lv[3] = 1700 + ($urandom % 2201);
    foreach (lv[i]) begin
      @(posedge clk) level <= 13'(lv[i]);
      tick(4);
      cnt = 0;
      repeat (2201) begin
        tick(1);
        cnt += (lower != 3'h0);
      end
      chk_val("duty", 32'(lv[i] - 1700), 32'(cnt));
    end
    @(posedge clk) level <= 13'hFA0;
    $display("test pwm done");
    @(posedge clk);
    brake_n <= 1'b0;
    overload <= 1'b1;
    tick(4);
    chk_val("brake", 32'h3F, 32'({lower, upper_n}));
    tick(20);
    chk_val("brake limit", 32'h3F, 32'({lower, upper_n}));
    @(posedge clk);
    at_trip <= 1'b1;
    above_rel <= 1'b0;
    tick(3);
    chk_val("lockout", 32'h07, 32'({lower, upper_n}));
    chk_val("flag low", 32'h0, 32'(flag_n));
    @(posedge clk) at_trip <= 1'b0;
    tick(3);
    chk_val("flag held", 32'h0, 32'(flag_n));
    chk_val("held off", 32'h07, 32'({lower, upper_n}));
    @(posedge clk) above_rel <= 1'b1;
    tick(3);
    chk_val("flag free", 32'h1, 32'(flag_n));
    chk_val("brake again", 32'h3F, 32'({lower, upper_n}));
    rd_chk("irq events", 8'h08, 32'h4, 2'h0);
    @(posedge clk);
    brake_n <= 1'b1;
    overload <= 1'b0;
    tick(3);
    chk_drv("resume", 1);
    chk_val("shoot", 32'h0, 32'(shoot));
    $display("test brake and lockout done");
    stop_test();
  end
endmodule : tb
